// ### rtl/frts_defines.vh
//////////////////////////////////////////////////////////////////////////////
// Purpose : Constants for the raw and thermal fault status bank
// Assumes : Included by bare name from rtl files
// Notes   : Definitions only
//////////////////////////////////////////////////////////////////////////////
`ifndef FRTS_DEFINES_VH
`define FRTS_DEFINES_VH

// Register word and address widths
`define FRTS_DATA_W            16
`define FRTS_ADDR_W            6

// Register offsets
`define FRTS_OFS_RAW           6'h02
`define FRTS_OFS_THERM         6'h04

// Reset values
`define FRTS_RST_RAW           16'h0280
`define FRTS_RST_THERM         16'h0000
`define FRTS_ZERO_WORD         16'h0000

// Common field
`define FRTS_BIT_PARITY        15

// Raw status fields
`define FRTS_RAW_DRIVER_DISABLE_PIN       12
`define FRTS_RAW_TW_LIVE       11
`define FRTS_RAW_NOT_READY     9
`define FRTS_RAW_OTP_FAULT     8
`define FRTS_RAW_POR           7
`define FRTS_RAW_SER_FAULT     6
`define FRTS_RAW_OVERCURRENT   5
`define FRTS_RAW_OVERVOLT      3
`define FRTS_RAW_PUMP_UV       2
`define FRTS_RAW_TSD_LIVE      1

// Thermal status fields
`define FRTS_THM_WARN          1
`define FRTS_THM_SHUTDOWN      0

`endif

// ### rtl/frts_parity.v
//////////////////////////////////////////////////////////////////////////////
// Purpose : Even parity helper for one 16-bit serial data block
// Assumes : Purely combinational, no state
// Notes   : odd_out high means the block holds an odd number of ones
//////////////////////////////////////////////////////////////////////////////
`include "frts_defines.vh"

module frts_parity (
  // Block under test
  input  wire [`FRTS_DATA_W-1:0] word_in,
  // Result
  output wire                    odd_out
);

  assign odd_out = ^word_in;

endmodule // frts_parity

// ### rtl/frts_status_bank.v
//////////////////////////////////////////////////////////////////////////////
// Purpose : Raw fault status and latched thermal status registers
// Assumes : All inputs synchronous to mclk_in; event inputs are
//           one-cycle pulses, condition inputs are levels
// Notes   : Frame decoding lives elsewhere; this bank sees a parsed
//           read or write request with a 6-bit register address
//////////////////////////////////////////////////////////////////////////////
`include "frts_defines.vh"

module frts_status_bank (
  // Clock and reset
  input  wire                    mclk_in,
  input  wire                    reset_in,

  // Configuration and clear sources
  input  wire                    parity_check_enable_in,
  input  wire                    fault_clear_command_in,
  input  wire                    sleep_reset_pulse_in,

  // Live conditions (levels)
  input  wire                    driver_disable_pin_in,
  input  wire                    thermal_warning_in,
  input  wire                    thermal_shutdown_in,
  input  wire                    overvoltage_in,
  input  wire                    pump_undervoltage_in,
  input  wire                    power_up_done_in,

  // Fault events (pulses)
  input  wire                    otp_read_fault_in,
  input  wire                    serial_fault_in,
  input  wire                    overcurrent_in,
  input  wire                    auto_retry_done_in,

  // Register read request
  input  wire                    rd_req_in,
  input  wire [`FRTS_ADDR_W-1:0] rd_addr_in,

  // Register write request
  input  wire                    wr_req_in,
  input  wire [`FRTS_ADDR_W-1:0] wr_addr_in,
  input  wire [`FRTS_DATA_W-1:0] wr_data_in,

  // Read answer
  output reg                     rd_valid_out,
  output reg                     rd_hit_out,
  output reg  [`FRTS_DATA_W-1:0] rd_data_out,

  // Write answer
  output reg                     wr_parity_err_out,
  output reg                     wr_ignored_out,

  // Register images for the rest of the device
  output reg  [`FRTS_DATA_W-1:0] raw_status_out,
  output reg  [`FRTS_DATA_W-1:0] thermal_status_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Sticky flag: a set in the same cycle as a clear wins
  function latch_next;
    input cur;
    input set;
    input clr;
    begin
      latch_next = set | (cur & ~clr);
    end
  endfunction

  // Address decode used by the write path; the read path decodes the address itself
  function addr_is_mapped;
    input [`FRTS_ADDR_W-1:0] addr;
    begin
      if (addr == `FRTS_OFS_RAW) begin
        addr_is_mapped = 1'b1;
      end else if (addr == `FRTS_OFS_THERM) begin
        addr_is_mapped = 1'b1;
      end else begin
        addr_is_mapped = 1'b0;
      end
    end
  endfunction

  // Place the raw flags at their bit positions; reserved bits read zero
  function [`FRTS_DATA_W-1:0] raw_word;
    input driver_disable_pin;
    input warn;
    input not_ready;
    input otp;
    input por;
    input ser;
    input oc;
    input ov;
    input uv;
    input tsd;
    begin
      raw_word                        = `FRTS_ZERO_WORD;
      raw_word[`FRTS_RAW_DRIVER_DISABLE_PIN]     = driver_disable_pin;
      raw_word[`FRTS_RAW_TW_LIVE]     = warn;
      raw_word[`FRTS_RAW_NOT_READY]   = not_ready;
      raw_word[`FRTS_RAW_OTP_FAULT]   = otp;
      raw_word[`FRTS_RAW_POR]         = por;
      raw_word[`FRTS_RAW_SER_FAULT]   = ser;
      raw_word[`FRTS_RAW_OVERCURRENT] = oc;
      raw_word[`FRTS_RAW_OVERVOLT]    = ov;
      raw_word[`FRTS_RAW_PUMP_UV]     = uv;
      raw_word[`FRTS_RAW_TSD_LIVE]    = tsd;
    end
  endfunction

  // Thermal register: only the two latched bits carry state
  function [`FRTS_DATA_W-1:0] therm_word;
    input warn;
    input shutdown;
    begin
      therm_word                      = `FRTS_ZERO_WORD;
      therm_word[`FRTS_THM_WARN]      = warn;
      therm_word[`FRTS_THM_SHUTDOWN]  = shutdown;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  reg  driver_off_live_flag_q;
  reg  thermal_warning_live_flag_q;
  reg  not_ready_live_flag_q;
  reg  otp_read_fault_flag_q;
  reg  power_on_flag_q;
  reg  serial_fault_flag_q;
  reg  overcurrent_flag_q;
  reg  overvoltage_live_flag_q;
  reg  pump_undervoltage_live_flag_q;
  reg  thermal_shutdown_live_flag_q;
  reg  thermal_warning_latched_q;
  reg  thermal_shutdown_latched_q;

  // Sources that clear most latched faults
  wire common_clear;
  assign common_clear = fault_clear_command_in | sleep_reset_pulse_in;

  ////////////////////////////////////////////////////////////////////////////
  // Next flag values; the exported images are built from these so that
  // they show the same state as the flags instead of trailing by a cycle

  reg  not_ready_live_flag_d;
  reg  otp_read_fault_flag_d;
  reg  power_on_flag_d;
  reg  serial_fault_flag_d;
  reg  overcurrent_flag_d;
  reg  thermal_warning_latched_d;
  reg  thermal_shutdown_latched_d;

  always @* begin
    not_ready_live_flag_d      = not_ready_live_flag_q & ~power_up_done_in;
    // Sleep pulse must not hide a memory read fault
    otp_read_fault_flag_d      = latch_next(otp_read_fault_flag_q, otp_read_fault_in,
                                            fault_clear_command_in);
    // No set source after reset: only a new reset raises it again
    power_on_flag_d            = latch_next(power_on_flag_q, 1'b0,
                                            common_clear);
    serial_fault_flag_d        = latch_next(serial_fault_flag_q, serial_fault_in,
                                            common_clear);
    overcurrent_flag_d         = latch_next(overcurrent_flag_q, overcurrent_in,
                                            common_clear | auto_retry_done_in);
    thermal_warning_latched_d  = latch_next(thermal_warning_latched_q, thermal_warning_in,
                                            common_clear);
    thermal_shutdown_latched_d = latch_next(thermal_shutdown_latched_q, thermal_shutdown_in,
                                            common_clear);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Live flags
  // One register stage keeps every readable bit glitch free; the cost is
  // one cycle of lag behind the condition.

  always @(posedge mclk_in) begin
    if (reset_in) begin
      driver_off_live_flag_q        <= 1'b0;
      thermal_warning_live_flag_q   <= 1'b0;
      overvoltage_live_flag_q       <= 1'b0;
      pump_undervoltage_live_flag_q <= 1'b0;
      thermal_shutdown_live_flag_q  <= 1'b0;
    end else begin
      driver_off_live_flag_q        <= driver_disable_pin_in;
      thermal_warning_live_flag_q   <= thermal_warning_in;
      overvoltage_live_flag_q       <= overvoltage_in;
      pump_undervoltage_live_flag_q <= pump_undervoltage_in;
      thermal_shutdown_live_flag_q  <= thermal_shutdown_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Not-ready flag
  // Only reset brings it back; a sleep pulse alone does not repeat power-up.

  always @(posedge mclk_in) begin
    if (reset_in) begin
      not_ready_live_flag_q <= 1'b1;
    end else begin
      not_ready_live_flag_q <= not_ready_live_flag_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latched raw faults

  always @(posedge mclk_in) begin
    if (reset_in) begin
      otp_read_fault_flag_q <= 1'b0;
      power_on_flag_q       <= 1'b1;
      serial_fault_flag_q   <= 1'b0;
      overcurrent_flag_q    <= 1'b0;
    end else begin
      otp_read_fault_flag_q <= otp_read_fault_flag_d;
      power_on_flag_q       <= power_on_flag_d;
      serial_fault_flag_q   <= serial_fault_flag_d;
      overcurrent_flag_q    <= overcurrent_flag_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latched thermal faults
  // Conditions are levels, so the flag re-sets each cycle the condition
  // persists and a clear only sticks once the condition has gone.

  always @(posedge mclk_in) begin
    if (reset_in) begin
      thermal_warning_latched_q  <= 1'b0;
      thermal_shutdown_latched_q <= 1'b0;
    end else begin
      thermal_warning_latched_q  <= thermal_warning_latched_d;
      thermal_shutdown_latched_q <= thermal_shutdown_latched_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register images (bit 15 left clear; parity is added on the way out)

  reg [`FRTS_DATA_W-1:0] raw_image;
  reg [`FRTS_DATA_W-1:0] therm_image;
  reg [`FRTS_DATA_W-1:0] raw_image_d;
  reg [`FRTS_DATA_W-1:0] therm_image_d;

  always @* begin
    raw_image     = raw_word(driver_off_live_flag_q, thermal_warning_live_flag_q,
                             not_ready_live_flag_q, otp_read_fault_flag_q, power_on_flag_q,
                             serial_fault_flag_q, overcurrent_flag_q, overvoltage_live_flag_q,
                             pump_undervoltage_live_flag_q, thermal_shutdown_live_flag_q);
    raw_image_d   = raw_word(driver_disable_pin_in, thermal_warning_in,
                             not_ready_live_flag_d, otp_read_fault_flag_d, power_on_flag_d,
                             serial_fault_flag_d, overcurrent_flag_d, overvoltage_in,
                             pump_undervoltage_in, thermal_shutdown_in);
    therm_image   = therm_word(thermal_warning_latched_q, thermal_shutdown_latched_q);
    therm_image_d = therm_word(thermal_warning_latched_d, thermal_shutdown_latched_d);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  reg  [`FRTS_DATA_W-1:0] rd_sel;
  reg                     rd_hit;
  wire                    rd_odd;

  always @* begin
    rd_sel = `FRTS_ZERO_WORD;
    rd_hit = 1'b0;
    if (rd_addr_in == `FRTS_OFS_RAW) begin
      rd_sel = raw_image;
      rd_hit = 1'b1;
    end else if (rd_addr_in == `FRTS_OFS_THERM) begin
      rd_sel = therm_image;
      rd_hit = 1'b1;
    end
  end

  frts_parity u_rd_parity (
    .word_in (rd_sel),
    .odd_out (rd_odd)
  );

  // With parity_check_enable_in high the parity bit makes the whole block even, otherwise it reads zero; unmapped reads return zero
  reg [`FRTS_DATA_W-1:0] rd_data_d;

  always @* begin
    rd_data_d = rd_sel;
    rd_data_d[`FRTS_BIT_PARITY] = parity_check_enable_in & rd_odd;
  end

  always @(posedge mclk_in) begin
    if (reset_in) begin
      rd_valid_out <= 1'b0;
      rd_hit_out   <= 1'b0;
      rd_data_out  <= `FRTS_ZERO_WORD;
    end else begin
      rd_valid_out <= rd_req_in;
      if (rd_req_in) begin
        rd_hit_out  <= rd_hit;
        rd_data_out <= rd_data_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write path
  // Both registers are read-only, so a write never changes state; it is
  // still checked so the frame logic can report a parity failure.

  wire wr_odd;

  frts_parity u_wr_parity (
    .word_in (wr_data_in),
    .odd_out (wr_odd)
  );

  wire wr_bad_parity;
  assign wr_bad_parity = parity_check_enable_in & wr_odd;

  always @(posedge mclk_in) begin
    if (reset_in) begin
      wr_parity_err_out <= 1'b0;
      wr_ignored_out    <= 1'b0;
    end else begin
      wr_parity_err_out <= wr_req_in & wr_bad_parity;
      // Good-parity write to a mapped address is dropped
      wr_ignored_out    <= wr_req_in & ~wr_bad_parity &
                           addr_is_mapped(wr_addr_in);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register images out

  always @(posedge mclk_in) begin
    if (reset_in) begin
      raw_status_out     <= `FRTS_RST_RAW;
      thermal_status_out <= `FRTS_RST_THERM;
    end else begin
      raw_status_out     <= raw_image_d;
      thermal_status_out <= therm_image_d;
    end
  end

endmodule // frts_status_bank

// ### test/frts_status_sva.sv
// Purpose : Port-level checks of the raw and thermal fault status bank
// Assumes : One clock, synchronous active-high reset
// Notes   : Live bits lag their inputs by one register stage
`include "frts_defines.vh"
module frts_status_sva (
  // Clock and reset
  input wire logic        mclk_in,
  input wire logic        reset_in,
  // Controls and conditions
  input wire logic        parity_check_enable_in,
  input wire logic        fault_clear_command_in,
  input wire logic        sleep_reset_pulse_in,
  input wire logic        driver_disable_pin_in,
  input wire logic        thermal_warning_in,
  input wire logic        thermal_shutdown_in,
  input wire logic        overvoltage_in,
  input wire logic        pump_undervoltage_in,
  input wire logic        otp_read_fault_in,
  input wire logic        serial_fault_in,
  input wire logic        overcurrent_in,
  input wire logic        auto_retry_done_in,
  // Requests
  input wire logic        rd_req_in,
  input wire logic [5:0]  rd_addr_in,
  input wire logic        wr_req_in,
  input wire logic [5:0]  wr_addr_in,
  input wire logic [15:0] wr_data_in,
  // Answers and images
  input wire logic        rd_valid_out,
  input wire logic        rd_hit_out,
  input wire logic [15:0] rd_data_out,
  input wire logic        wr_parity_err_out,
  input wire logic        wr_ignored_out,
  input wire logic [15:0] raw_status_out,
  input wire logic [15:0] thermal_status_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  sequence s_rd(a);
    rd_req_in && rd_addr_in == a ##1 rd_valid_out;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_read_latency: assert property (rd_req_in |=> rd_valid_out)
    else $error("read answer missing");
  a_unmapped_zero: assert property (rd_req_in && rd_addr_in != `FRTS_OFS_RAW
    && rd_addr_in != `FRTS_OFS_THERM |=> !rd_hit_out && rd_data_out == 16'h0000)
    else $error("unmapped read not zero");
  a_raw_read: assert property (s_rd(`FRTS_OFS_RAW) |-> rd_hit_out
    && rd_data_out[14:0] == $past(raw_status_out[14:0])) else $error("raw read wrong");
  a_read_parity: assert property (rd_valid_out |-> ($past(parity_check_enable_in) ?
    (^rd_data_out) == 1'b0 : !rd_data_out[15])) else $error("read parity wrong");
  a_raw_reserved: assert property ((raw_status_out & 16'hE011) == 16'h0000)
    else $error("raw reserved bit set");
  a_therm_reserved: assert property (thermal_status_out[15:2] == 14'h0000)
    else $error("thermal reserved bit set");
  a_live_bits: assert property (1'b1 |=> {raw_status_out[12:11], raw_status_out[3:1]}
    == $past({driver_disable_pin_in, thermal_warning_in, overvoltage_in,
    pump_undervoltage_in, thermal_shutdown_in})) else $error("live bit wrong");
  a_event_set: assert property (1'b1 |=> ({raw_status_out[8], raw_status_out[6:5],
    thermal_status_out[1:0]} | ~$past({otp_read_fault_in, serial_fault_in,
    overcurrent_in, thermal_warning_in, thermal_shutdown_in})) == 5'h1f)
    else $error("fault not latched");
  a_fault_clear: assert property (fault_clear_command_in && !otp_read_fault_in
    && !serial_fault_in && !overcurrent_in && !thermal_warning_in && !thermal_shutdown_in
    |=> raw_status_out[8:5] == 4'h0 && thermal_status_out == 16'h0000)
    else $error("fault clear missed");
  a_sleep_clear: assert property (sleep_reset_pulse_in && !otp_read_fault_in
    && !fault_clear_command_in && !serial_fault_in && !overcurrent_in
    && !thermal_warning_in && !thermal_shutdown_in
    |=> raw_status_out[7:5] == 3'h0 && thermal_status_out == 16'h0000
    && raw_status_out[8] == $past(raw_status_out[8])) else $error("sleep clear wrong");
  a_retry_clear: assert property (auto_retry_done_in && !overcurrent_in
    |=> !raw_status_out[5]) else $error("retry clear missed");
  a_power_flag_once: assert property (!raw_status_out[7] |=> !raw_status_out[7])
    else $error("power flag rose");
  a_ready_sticky: assert property (!raw_status_out[9] |=> !raw_status_out[9])
    else $error("not ready rose");
  a_write_answer: assert property (wr_req_in |=> wr_parity_err_out ==
    $past(parity_check_enable_in && ^wr_data_in) && wr_ignored_out ==
    $past(!(parity_check_enable_in && ^wr_data_in) && (wr_addr_in == `FRTS_OFS_RAW
    || wr_addr_in == `FRTS_OFS_THERM))) else $error("write answer wrong");
endmodule // frts_status_sva

bind frts_status_bank frts_status_sva u_sva (.mclk_in, .reset_in, .parity_check_enable_in,
  .fault_clear_command_in, .sleep_reset_pulse_in, .driver_disable_pin_in,
  .thermal_warning_in, .thermal_shutdown_in, .overvoltage_in, .pump_undervoltage_in,
  .otp_read_fault_in, .serial_fault_in, .overcurrent_in, .auto_retry_done_in, .rd_req_in,
  .rd_addr_in, .wr_req_in, .wr_addr_in, .wr_data_in, .rd_valid_out, .rd_hit_out,
  .rd_data_out, .wr_parity_err_out, .wr_ignored_out, .raw_status_out, .thermal_status_out);

// ### test/frts_host_model.sv
// Purpose : Host controller model issuing parsed register reads and writes
// Assumes : Requests change 1 ns after a rising edge
// Notes   : Released lines are inverted so stale values never look valid
`include "frts_defines.vh"
module frts_host_model (
  // Clock
  input  wire logic        mclk_in,
  // Requests
  output logic             rd_req_out,
  output logic [5:0]       rd_addr_out,
  output logic             wr_req_out,
  output logic [5:0]       wr_addr_out,
  output logic [15:0]      wr_data_out,
  // Answers
  input  wire logic        rd_valid_in,
  input  wire logic        rd_hit_in,
  input  wire logic [15:0] rd_data_in,
  input  wire logic        wr_parity_err_in,
  input  wire logic        wr_ignored_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rd_req_out  = 1'b0;
    wr_req_out  = 1'b0;
    rd_addr_out = 6'h00;
    wr_addr_out = 6'h00;
    wr_data_out = 16'h0000;
  end
  task automatic rd(input logic [5:0] a, output logic [15:0] d, output logic h);
    @(posedge mclk_in);
    #1;
    rd_req_out  = 1'b1;
    rd_addr_out = a;
    @(posedge mclk_in);
    #1;
    d           = rd_data_in;
    h           = rd_valid_in & rd_hit_in;
    rd_req_out  = 1'b0;
    rd_addr_out = ~a;
  endtask
  // Bad parity is sent whenever a scenario sets bad, also with parity checking off where no refusal follows
  task automatic wr(input logic [5:0] a, input logic [14:0] v, input logic bad,
                    output logic [1:0] r);
    @(posedge mclk_in);
    #1;
    wr_req_out  = 1'b1;
    wr_addr_out = a;
    wr_data_out = {(^v) ^ bad, v};
    @(posedge mclk_in);
    #1;
    r           = {wr_parity_err_in, wr_ignored_in};
    wr_req_out  = 1'b0;
    wr_addr_out = ~a;
    wr_data_out = ~wr_data_out;
  endtask
endmodule // frts_host_model

// ### test/tb.sv
// Purpose : Self-checking bench for the fault status bank
// Assumes : 25 MHz clock, inputs driven 1 ns after rising edges
// Notes   : Event inputs are one-cycle pulses from a shared vector
`include "frts_defines.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
  $display("BAD %0t got %h exp %h", $time, a, b); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_in, reset_in, par, rd_req, wr_req, rd_valid, rd_hit, perr, ign, h;
  logic [4:0]  lv;  // drv, warn, overvolt, undervolt, shutdown
  logic [6:0]  ev;  // otp, serial, overcurrent, retry, clear, sleep, power-up
  logic [5:0]  rd_addr, wr_addr;
  logic [15:0] wr_data, rd_data, raw, therm, d;
  logic [1:0]  r;
  int          bad_count, checked, cycles;
  const logic [15:0] lvmap[5] = '{16'h0002, 16'h0004, 16'h0008, 16'h0800, 16'h1000};
  frts_status_bank DUT (.mclk_in(mclk_in), .reset_in(reset_in),
    .parity_check_enable_in(par), .fault_clear_command_in(ev[2]),
    .sleep_reset_pulse_in(ev[1]), .driver_disable_pin_in(lv[4]), .thermal_warning_in(lv[3]),
    .thermal_shutdown_in(lv[0]), .overvoltage_in(lv[2]), .pump_undervoltage_in(lv[1]),
    .power_up_done_in(ev[0]), .otp_read_fault_in(ev[6]), .serial_fault_in(ev[5]),
    .overcurrent_in(ev[4]), .auto_retry_done_in(ev[3]), .rd_req_in(rd_req),
    .rd_addr_in(rd_addr), .wr_req_in(wr_req), .wr_addr_in(wr_addr), .wr_data_in(wr_data),
    .rd_valid_out(rd_valid), .rd_hit_out(rd_hit), .rd_data_out(rd_data),
    .wr_parity_err_out(perr), .wr_ignored_out(ign), .raw_status_out(raw),
    .thermal_status_out(therm));
  frts_host_model host (.mclk_in(mclk_in), .rd_req_out(rd_req), .rd_addr_out(rd_addr),
    .wr_req_out(wr_req), .wr_addr_out(wr_addr), .wr_data_out(wr_data),
    .rd_valid_in(rd_valid), .rd_hit_in(rd_hit), .rd_data_in(rd_data),
    .wr_parity_err_in(perr), .wr_ignored_in(ign));
  //////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("TB: checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic pulse(input int b);
    @(posedge mclk_in);
    #1;
    ev[b] = 1'b1;
    @(posedge mclk_in);
    #1;
    ev[b] = 1'b0;
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [15:0] e, input logic eh);
    host.rd(a, d, h);
    `CHK(d, e)
    `CHK(h, eh)
  endtask
  task automatic wr_chk(input logic [5:0] a, input logic [14:0] v, input logic b,
                        input logic [1:0] e);
    host.wr(a, v, b, r);
    `CHK(r, e)
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end
  // Whole run is about 80 cycles; the ceiling leaves ample margin
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      test_done();
    end
  end
  initial begin
    par      = 1'b0;
    lv       = 5'h00;
    ev       = 7'h00;
    reset_in = 1'b1;
    repeat (6) @(posedge mclk_in);
    #1;
    reset_in = 1'b0;
    rd_chk(`FRTS_OFS_RAW, `FRTS_RST_RAW, 1'b1);
    rd_chk(`FRTS_OFS_THERM, 16'h0000, 1'b1);
    rd_chk(6'h03, 16'h0000, 1'b0);
    pulse(0);
    rd_chk(`FRTS_OFS_RAW, 16'h0080, 1'b1);
    pulse(2);
    rd_chk(`FRTS_OFS_RAW, 16'h0000, 1'b1);
    for (int i = 0; i < 5; i++) begin
      lv = 5'h01 << i;
      rd_chk(`FRTS_OFS_RAW, lvmap[i], 1'b1);
    end
    lv = 5'h00;
    rd_chk(`FRTS_OFS_THERM, 16'h0003, 1'b1);
    pulse(1);
    rd_chk(`FRTS_OFS_THERM, 16'h0000, 1'b1);
    pulse(6);
    pulse(5);
    pulse(4);
    rd_chk(`FRTS_OFS_RAW, 16'h0160, 1'b1);
    pulse(1);
    rd_chk(`FRTS_OFS_RAW, 16'h0100, 1'b1);
    pulse(4);
    pulse(3);
    rd_chk(`FRTS_OFS_RAW, 16'h0100, 1'b1);
    pulse(5);
    pulse(4);
    par = 1'b1;
    rd_chk(`FRTS_OFS_RAW, 16'h8160, 1'b1);
    wr_chk(`FRTS_OFS_RAW, 15'h0001, 1'b0, 2'b01);
    wr_chk(`FRTS_OFS_THERM, 15'h0001, 1'b1, 2'b10);
    wr_chk(6'h05, 15'h0003, 1'b0, 2'b00);
    rd_chk(`FRTS_OFS_RAW, 16'h8160, 1'b1);
    pulse(2);
    rd_chk(`FRTS_OFS_RAW, 16'h0000, 1'b1);
    par = 1'b0;
    wr_chk(`FRTS_OFS_THERM, 15'h7fff, 1'b1, 2'b01);
    reset_in = 1'b1;
    repeat (2) @(posedge mclk_in);
    #1;
    reset_in = 1'b0;
    rd_chk(`FRTS_OFS_RAW, `FRTS_RST_RAW, 1'b1);
    test_done();
  end
endmodule // tb
